// ===== logic/sss_map.svh
// Register offsets, field positions, reset values and timing counts
`ifndef SSS_MAP_SVH
`define SSS_MAP_SVH
`define SSS_OFF_SEL 8'h00
`define SSS_OFF_HOLD 8'h04
`define SSS_OFF_TORQ 8'h08
`define SSS_OFF_CMD 8'h0C
`define SSS_OFF_STAT 8'h10
`define SSS_OFF_IRQ 8'h14
`define SSS_OFF_MASK 8'h18
`define SSS_SEL_SUP 3:0
`define SSS_SEL_SOFF 7:4
`define SSS_SEL_ALM 11:8
`define SSS_SEL_LIM 13:12
`define SSS_SEL_UV 16
`define SSS_CMD_ON 0
`define SSS_CMD_ACLR 1
`define SSS_RST_SUP 4'h0
`define SSS_RST_SOFF 4'h0
`define SSS_RST_ALM 4'h0
`define SSS_RST_LIM 2'h0
`define SSS_RST_UV 1'h1
`define SSS_RST_HOLD 11'h046
`define SSS_RST_TORQ 9'h000
`define SSS_STD_MAX 4'h9
`define SSS_ALM_MAX 4'h7
`define SSS_LIM_MAX 2'h2
`define SSS_HOLD_MIN 11'h046
`define SSS_HOLD_OFF 11'h7D0
`define SSS_TORQ_MAX 9'h1F4
`define SSS_TIME_MS 1
`define SSS_CLK_MHZ 100
`define SSS_CYC_PER_MS (`SSS_TIME_MS * `SSS_CLK_MHZ * 1000)
`define SSS_IRQ_W 3
`define SSS_IRQ_LOSS 0
`define SSS_IRQ_UV 1
`define SSS_IRQ_STOP 2
`endif

// ===== logic/sss_pkg.sv
// Types shared by the stop sequence selector
`default_nettype none
package sss_pkg;
   typedef enum logic [1:0] {
      SSS_D_BRAKE = 2'h0,
      SSS_D_FREE = 2'h1,
      SSS_D_ESTOP = 2'h2
   } sss_decel_t;
   typedef enum logic [1:0] {
      SSS_A_BRAKE = 2'h0,
      SSS_A_FREE = 2'h1,
      SSS_A_LIMIT = 2'h2
   } sss_after_t;
   typedef enum logic [1:0] {
      SSS_ST_OFF = 2'h0,
      SSS_ST_RUN = 2'h1,
      SSS_ST_DECEL = 2'h3,
      SSS_ST_AFTER = 2'h2
   } sss_state_t;
   typedef struct packed {
      sss_decel_t decel;
      sss_after_t after;
      logic clr_decel;
      logic clr_after;
   } sss_mode_t;
   typedef struct packed {
      logic brake;
      logic free_run;
      logic servo_free;
      logic estop;
      logic energised;
      logic err_clear;
      logic prohibit_zero_torque;
      logic [8:0] torque_limit;
   } sss_drive_t;
endpackage
`default_nettype wire

// ===== logic/sss_selector.sv
// Stop sequence selector for a servo drive with an APB register slave
`include "sss_map.svh"
`default_nettype none
// How it works
// - Supply-loss stop select holds 0 to 9, resets to 0.
// - Codes 0-9 pick decel and after-stop behaviour; all clear the counter.
// - Decel ends at first low-speed sample; after-stop then holds.
// - Emergency-stop decel keeps servo energised with limited torque.
// - Alarm during supply loss uses the alarm stop select.
// - In servo-off, alarms use alarm select, supply loss uses its own.
// - Undervoltage select 0: servo off on loss, back on when restored.
// - Undervoltage select 1: loss while servo-on raises alarm 13.1.
// - Loss is detected after hold time of 70 to 1999 ms.
// - Hold time of 2000 disables supply-loss detection.
// - Alarm stop select holds 0 to 7, resets to 0.
// - Alarm codes 4-7 add emergency stop, else mirror 0-3.
// - Emergency stop only for alarms that support it.
// - Emergency stop torque limit 0 to 500 percent of rated.
// - Estop torque applies for limit code 2, codes 8 or 9, and alarm codes 4-7 on capable alarms.
// - Estop torque of 0 falls back to the normal limit.
// - Servo-off stop select 0 to 9 uses the supply-loss encoding.
// - Limit code 2 stops by estop holding the error counter.
module sss_selector
   import sss_pkg::*;
#(
   parameter int CYC_PER_MS = `SSS_CYC_PER_MS
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic mains_ok,
   input wire logic alarm_in,
   input wire logic alarm_estop_capable,
   input wire logic prohibit_in,
   input wire logic speed_low,
   input wire logic [8:0] normal_torque_limit,
   output sss_drive_t drive,
   output logic alarm_13_1,
   output logic irq
);

   function automatic sss_mode_t dec_std(input logic [3:0] c);
      sss_mode_t m;
      m.clr_decel = 1'b1;
      m.clr_after = 1'b1;
      m.decel = c[0] ? SSS_D_FREE : SSS_D_BRAKE;
      m.after = c[1] ? SSS_A_FREE : SSS_A_BRAKE;
      if (c == 4'h8 || c == 4'h9) begin
         m.decel = SSS_D_ESTOP;
         m.after = c[0] ? SSS_A_FREE : SSS_A_BRAKE;
      end
      return m;
   endfunction

   function automatic sss_mode_t dec_alm(input logic [3:0] c,
                                         input logic cap);
      sss_mode_t m;
      m = dec_std({2'h0, c[1:0]});
      if (c[2] && cap) begin
         m.decel = SSS_D_ESTOP;
      end
      return m;
   endfunction

   function automatic sss_mode_t dec_lim(input logic [1:0] c);
      sss_mode_t m;
      m.after = SSS_A_LIMIT;
      m.clr_decel = 1'b1;
      m.clr_after = 1'b0;
      m.decel = (c == 2'h1) ? SSS_D_FREE : SSS_D_BRAKE;
      if (c == `SSS_LIM_MAX) begin
         m.decel = SSS_D_ESTOP;
         m.clr_decel = 1'b0;
      end
      return m;
   endfunction

   localparam int MSW = $clog2(CYC_PER_MS + 1);

   logic [3:0] sup_sel_ff;
   logic [3:0] soff_sel_ff;
   logic [3:0] alm_sel_ff;
   logic [1:0] lim_sel_ff;
   logic uv_sel_ff;
   logic [10:0] hold_ff;
   logic [8:0] etorq_ff;
   logic servo_req_ff;
   logic [`SSS_IRQ_W-1:0] irq_ff;
   logic [`SSS_IRQ_W-1:0] mask_ff;
   logic [31:0] prdata_ff;
   logic [MSW-1:0] div_ff;
   logic [10:0] loss_ms_ff;
   logic lost_ff;
   logic uv_alarm_ff;
   logic alarm_d_ff;
   logic lim_d_ff;
   logic lim_code2_ff;
   logic lim_cleared_ff;
   sss_state_t state_ff;
   sss_state_t nxt_state;
   sss_mode_t mode_ff;
   sss_mode_t nxt_mode;
   sss_drive_t drive_ff;
   sss_drive_t nxt_drive;

   wire setup = psel & ~penable;
   wire access = psel & penable;
   wire wr = access & pwrite;
   wire a_sel = paddr == `SSS_OFF_SEL;
   wire a_hold = paddr == `SSS_OFF_HOLD;
   wire a_torq = paddr == `SSS_OFF_TORQ;
   wire a_cmd = paddr == `SSS_OFF_CMD;
   wire a_stat = paddr == `SSS_OFF_STAT;
   wire a_irq = paddr == `SSS_OFF_IRQ;
   wire a_mask = paddr == `SSS_OFF_MASK;
   wire a_any = a_sel | a_hold | a_torq | a_cmd | a_stat | a_irq | a_mask;

   wire [3:0] w_sup = pwdata[`SSS_SEL_SUP];
   wire [3:0] w_soff = pwdata[`SSS_SEL_SOFF];
   wire [3:0] w_alm = pwdata[`SSS_SEL_ALM];
   wire [1:0] w_lim = pwdata[`SSS_SEL_LIM];
   wire [10:0] w_hold = pwdata[10:0];
   wire [8:0] w_torq = pwdata[8:0];
   wire sel_ok = (w_sup <= `SSS_STD_MAX) & (w_soff <= `SSS_STD_MAX)
               & (w_alm <= `SSS_ALM_MAX) & (w_lim <= `SSS_LIM_MAX);
   wire hold_ok = (w_hold >= `SSS_HOLD_MIN) & (w_hold <= `SSS_HOLD_OFF);
   wire torq_ok = w_torq <= `SSS_TORQ_MAX;
   wire range_bad = pwrite & ((a_sel & ~sel_ok) | (a_hold & ~hold_ok)
                  | (a_torq & ~torq_ok));
   wire wr_sel = wr & a_sel & sel_ok;
   wire wr_hold = wr & a_hold & hold_ok;
   wire wr_torq = wr & a_torq & torq_ok;
   wire wr_cmd = wr & a_cmd;
   wire wr_irq = wr & a_irq;
   wire wr_mask = wr & a_mask;
   wire alarm_clr = wr_cmd & pwdata[`SSS_CMD_ACLR];

   assign pready = 1'b1;
   assign pslverr = access & (~a_any | range_bad);
   assign prdata = prdata_ff;

   wire [31:0] rd_sel = {15'h0000, uv_sel_ff, 2'h0, lim_sel_ff,
                         alm_sel_ff, soff_sel_ff, sup_sel_ff};
   wire [31:0] rd_stat = {26'h0000000, mains_ok, lost_ff, uv_alarm_ff,
                          speed_low, state_ff};
   wire [31:0] rd_mux =
        a_sel ? rd_sel :
        a_hold ? {21'h000000, hold_ff} :
        a_torq ? {23'h000000, etorq_ff} :
        a_cmd ? {31'h00000000, servo_req_ff} :
        a_stat ? rd_stat :
        a_irq ? {29'h00000000, irq_ff} :
        a_mask ? {29'h00000000, mask_ff} : 32'h00000000;

   // Millisecond tick
   wire ms_tick = div_ff == MSW'(CYC_PER_MS - 1);
   wire loss_en = hold_ff != `SSS_HOLD_OFF;
   wire loss_hit = loss_en & ~mains_ok & ~lost_ff & (loss_ms_ff >= hold_ff);
   wire alarm_any = alarm_in | uv_alarm_ff;
   wire alarm_rise = alarm_any & ~alarm_d_ff;
   wire lim_rise = prohibit_in & ~lim_d_ff;
   wire uv_set = loss_hit & uv_sel_ff & (state_ff == SSS_ST_RUN);
   wire run_ok = servo_req_ff & ~lost_ff & ~alarm_any & ~prohibit_in;
   wire low_now = speed_low;

   logic [`SSS_IRQ_W-1:0] irq_ev;
   assign irq_ev[`SSS_IRQ_LOSS] = loss_hit;
   assign irq_ev[`SSS_IRQ_UV] = uv_set;
   assign irq_ev[`SSS_IRQ_STOP] = (state_ff == SSS_ST_DECEL) & low_now;
   assign irq = |(irq_ff & mask_ff);
   assign alarm_13_1 = uv_alarm_ff;

   // Mode chosen for a new stop cause; alarm outranks supply loss
   wire sm_alarm = alarm_rise | uv_set;
   wire sm_loss = loss_hit & ~uv_sel_ff;
   wire sm_loss_off = loss_hit & (state_ff != SSS_ST_RUN);
   wire sm_soff = (state_ff == SSS_ST_RUN) & ~servo_req_ff;
   wire sm_lim = (state_ff == SSS_ST_RUN) & lim_rise;
   wire new_cause = sm_alarm | sm_loss | sm_loss_off | sm_soff | sm_lim;
   sss_mode_t mode_alm;
   sss_mode_t mode_sup;
   sss_mode_t mode_soff;
   sss_mode_t mode_lim;
   assign mode_alm = dec_alm(alm_sel_ff, alarm_estop_capable);
   assign mode_sup = dec_std(sup_sel_ff);
   assign mode_soff = dec_std(soff_sel_ff);
   assign mode_lim = dec_lim(lim_sel_ff);

   always_comb begin
      nxt_mode = mode_ff;
      if (sm_alarm) begin
         nxt_mode = mode_alm;
      end else if (sm_loss | sm_loss_off) begin
         nxt_mode = mode_sup;
      end else if (sm_lim) begin
         nxt_mode = mode_lim;
      end else if (sm_soff) begin
         nxt_mode = mode_soff;
      end
   end

   always_comb begin
      nxt_state = state_ff;
      case (state_ff)
         SSS_ST_OFF: begin
            if (new_cause) begin
               nxt_state = low_now ? SSS_ST_AFTER : SSS_ST_DECEL;
            end else if (run_ok) begin
               nxt_state = SSS_ST_RUN;
            end
         end
         SSS_ST_RUN: begin
            if (new_cause) begin
               nxt_state = SSS_ST_DECEL;
            end
         end
         SSS_ST_DECEL: begin
            if (low_now) begin
               nxt_state = SSS_ST_AFTER;
            end
         end
         SSS_ST_AFTER: begin
            if (new_cause & ~low_now) begin
               nxt_state = SSS_ST_DECEL;
            end else if (run_ok) begin
               nxt_state = SSS_ST_RUN;
            end
         end
         default: begin
            nxt_state = SSS_ST_OFF;
         end
      endcase
   end

   // Drive outputs for the state being entered
   wire [8:0] etorq_eff = (etorq_ff == `SSS_RST_TORQ) ?
                          normal_torque_limit : etorq_ff;
   always_comb begin
      nxt_drive = '0;
      nxt_drive.torque_limit = normal_torque_limit;
      case (nxt_state)
         SSS_ST_RUN: begin
            nxt_drive.energised = 1'b1;
         end
         SSS_ST_DECEL: begin
            nxt_drive.err_clear = nxt_mode.clr_decel;
            case (nxt_mode.decel)
               SSS_D_ESTOP: begin
                  nxt_drive.estop = 1'b1;
                  nxt_drive.energised = 1'b1;
                  nxt_drive.torque_limit = etorq_eff;
               end
               SSS_D_FREE: begin
                  nxt_drive.free_run = 1'b1;
               end
               default: begin
                  nxt_drive.brake = 1'b1;
               end
            endcase
         end
         SSS_ST_AFTER: begin
            nxt_drive.err_clear = nxt_mode.clr_after;
            case (nxt_mode.after)
               SSS_A_LIMIT: begin
                  nxt_drive.energised = 1'b1;
                  nxt_drive.prohibit_zero_torque = ~lim_code2_ff;
                  nxt_drive.err_clear = lim_code2_ff & ~lim_cleared_ff;
               end
               SSS_A_FREE: begin
                  nxt_drive.servo_free = 1'b1;
               end
               default: begin
                  nxt_drive.brake = 1'b1;
               end
            endcase
         end
         default: begin
            nxt_drive.servo_free = 1'b1;
         end
      endcase
   end
   assign drive = drive_ff;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sup_sel_ff <= `SSS_RST_SUP;
         soff_sel_ff <= `SSS_RST_SOFF;
         alm_sel_ff <= `SSS_RST_ALM;
         lim_sel_ff <= `SSS_RST_LIM;
         uv_sel_ff <= `SSS_RST_UV;
      end else if (wr_sel) begin
         sup_sel_ff <= w_sup;
         soff_sel_ff <= w_soff;
         alm_sel_ff <= w_alm;
         lim_sel_ff <= w_lim;
         uv_sel_ff <= pwdata[`SSS_SEL_UV];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         hold_ff <= `SSS_RST_HOLD;
         etorq_ff <= `SSS_RST_TORQ;
         servo_req_ff <= 1'b0;
         mask_ff <= '0;
         prdata_ff <= 32'h00000000;
      end else begin
         if (wr_hold) begin
            hold_ff <= w_hold;
         end
         if (wr_torq) begin
            etorq_ff <= w_torq;
         end
         if (wr_cmd) begin
            servo_req_ff <= pwdata[`SSS_CMD_ON];
         end
         if (wr_mask) begin
            mask_ff <= pwdata[`SSS_IRQ_W-1:0];
         end
         if (setup) begin
            prdata_ff <= rd_mux;
         end
      end
   end

   // Sticky events, write one to clear, a new event wins
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_ff <= '0;
      end else begin
         irq_ff <= (irq_ff & ~(wr_irq ? pwdata[`SSS_IRQ_W-1:0] : '0))
                   | irq_ev;
      end
   end

   // Supply-loss timing in whole milliseconds
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         div_ff <= '0;
         loss_ms_ff <= '0;
         lost_ff <= 1'b0;
      end else begin
         div_ff <= (ms_tick | mains_ok) ? '0 : div_ff + MSW'(1);
         if (mains_ok) begin
            loss_ms_ff <= '0;
         end else if (ms_tick && loss_ms_ff != `SSS_HOLD_OFF) begin
            loss_ms_ff <= loss_ms_ff + 11'h001;
         end
         if (mains_ok | ~loss_en) begin
            lost_ff <= 1'b0;
         end else if (loss_hit) begin
            lost_ff <= 1'b1;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         uv_alarm_ff <= 1'b0;
         alarm_d_ff <= 1'b0;
         lim_d_ff <= 1'b0;
      end else begin
         alarm_d_ff <= alarm_any;
         lim_d_ff <= prohibit_in;
         if (uv_set) begin
            uv_alarm_ff <= 1'b1;
         end else if (alarm_clr & mains_ok) begin
            uv_alarm_ff <= 1'b0;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_ff <= SSS_ST_OFF;
         mode_ff <= '0;
         drive_ff <= '0;
         lim_code2_ff <= 1'b0;
         lim_cleared_ff <= 1'b0;
      end else begin
         state_ff <= nxt_state;
         mode_ff <= nxt_mode;
         drive_ff <= nxt_drive;
         if (sm_lim) begin
            lim_code2_ff <= lim_sel_ff == `SSS_LIM_MAX;
         end
         if (nxt_state != SSS_ST_AFTER) begin
            lim_cleared_ff <= 1'b0;
         end else begin
            lim_cleared_ff <= 1'b1;
         end
      end
   end

endmodule
`default_nettype wire

// ===== testbench/sss_selector_checker.sv
// Port checker for the stop sequence selector
`default_nettype none
module sss_selector_checker
   import sss_pkg::*;
#(
   parameter int CYC_PER_MS = 100000
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic mains_ok,
   input wire logic alarm_in,
   input wire logic alarm_estop_capable,
   input wire logic prohibit_in,
   input wire logic speed_low,
   input wire logic [8:0] normal_torque_limit,
   input wire sss_drive_t drive,
   input wire logic alarm_13_1,
   input wire logic irq
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [8:0] torq_ff;
   logic [8:0] nxt_torq;
   wire logic acc = psel && penable;
   wire logic wr = acc && pwrite;
   wire logic tq_ok = wr && paddr == 8'h08 && pwdata <= 32'h1F4;
   assign nxt_torq = tq_ok ? pwdata[8:0] : torq_ff;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) torq_ff <= 9'h000;
      else torq_ff <= nxt_torq;
   end
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   sequence s_stop_fast;
      (drive.free_run || drive.estop) && speed_low;
   endsequence
   sequence s_uv_rise;
      $rose(alarm_13_1);
   endsequence
   a_ready_access: assert property (acc |-> pready)
      else $error("pready low in access");
   a_unmapped_refused: assert property (acc && paddr > 8'h18
      |-> pslverr && (pwrite || prdata == 32'h0))
      else $error("unmapped access not refused");
   a_hold_refused: assert property (
      wr && paddr == 8'h04 && (pwdata < 32'h46 || pwdata > 32'h7D0)
      |-> pslverr) else $error("bad hold time accepted");
   a_sel_refused: assert property (
      wr && paddr == 8'h00 && (pwdata[3:0] > 4'h9 || pwdata[7:4] > 4'h9
      || pwdata[11:8] > 4'h7 || pwdata[13:12] > 2'h2) |-> pslverr)
      else $error("bad stop select accepted");
   a_estop_energised: assert property (drive.estop |->
      drive.energised && !drive.brake && !drive.free_run)
      else $error("estop without energised servo");
   a_estop_torque: assert property (
      drive.estop && $stable(torq_ff) && $stable(normal_torque_limit)
      |-> drive.torque_limit == ($past(torq_ff) == 9'h000 ?
      $past(normal_torque_limit) : $past(torq_ff)))
      else $error("estop torque limit wrong");
   a_one_stop_mode: assert property ($onehot0({drive.brake,
      drive.free_run, drive.servo_free, drive.estop}))
      else $error("several stop modes at once");
   a_decel_ends: assert property (s_stop_fast |=>
      !(drive.free_run || drive.estop))
      else $error("decel kept after low speed");
   a_uv_cause: assert property (s_uv_rise |-> !$past(mains_ok))
      else $error("uv alarm without supply loss");
   a_irq_fall: assert property ($fell(irq) |-> $past(wr))
      else $error("irq fell without a write");
endmodule
bind sss_selector sss_selector_checker #(.CYC_PER_MS(CYC_PER_MS)) chk (
   .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
   .pready(pready), .pslverr(pslverr), .mains_ok(mains_ok),
   .alarm_in(alarm_in), .alarm_estop_capable(alarm_estop_capable),
   .prohibit_in(prohibit_in), .speed_low(speed_low),
   .normal_torque_limit(normal_torque_limit), .drive(drive),
   .alarm_13_1(alarm_13_1), .irq(irq));
`default_nettype wire

// ===== testbench/sss_motor_model.sv
// Motor speed and main supply model facing the selector
`default_nettype none
module sss_motor_model
   import sss_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire sss_drive_t drive,
   input wire logic kick,
   input wire logic cut,
   output logic mains_ok,
   output logic speed_low
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [3:0] spd_ff;
   assign mains_ok = !cut;
   assign speed_low = spd_ff <= 4'h2;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) spd_ff <= 4'h0;
      else if (kick || (drive.energised && !drive.estop)) spd_ff <= 4'hF;
      else if (spd_ff != 4'h0) spd_ff <= spd_ff - 4'h1;
   end
endmodule
`default_nettype wire

// ===== testbench/sss_selector_tb_top.sv
// Self-checking bench for the stop sequence selector
`default_nettype none
module sss_selector_tb_top
   import sss_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   localparam logic [31:0] MS = 32'h3FC00;
   localparam logic [31:0] MT = 32'h3FDFF;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata;
   logic alarm_in, cap, prohibit_in, speed_low, mains_ok;
   logic alarm_13_1, irq, kick, cut, snap;
   logic [8:0] norm, tq;
   sss_drive_t drive;
   logic [63:0] exp_q[$];
   logic [7:0] ra[7] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h14, 8'h18, 8'h1C};
   logic [31:0] rv[7] = '{32'h10000, 32'h46, 0, 0, 0, 0, 0};
   int miscompares, samples_checked, cyc, seed, n, c;
   sss_selector #(.CYC_PER_MS(5)) uut (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .mains_ok(mains_ok),
      .alarm_in(alarm_in), .alarm_estop_capable(cap),
      .prohibit_in(prohibit_in), .speed_low(speed_low),
      .normal_torque_limit(norm), .drive(drive),
      .alarm_13_1(alarm_13_1), .irq(irq));
   sss_motor_model motor (.pclk(pclk), .presetn(presetn), .drive(drive),
      .kick(kick), .cut(cut), .mains_ok(mains_ok), .speed_low(speed_low));
   initial begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end
   task automatic stop_test;
      $display("Checked %0d, errors %0d", samples_checked, miscompares);
      if (miscompares == 0 && samples_checked > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   task automatic idle(input int k);
      repeat (k) @(posedge pclk);
   endtask
   task automatic apb(input logic w, input logic [7:0] a,
         input logic [31:0] d);
      int t;
      t = 0;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      if (!w) exp_q.push_back({32'hFFFFFFFF, d});
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         t++;
      end while (pready !== 1'b1 && t < 50);
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic chk(input logic [31:0] m, input logic [31:0] e);
      exp_q.push_back({m, e});
      @(posedge pclk);
      snap <= 1'b1;
      @(posedge pclk);
      snap <= 1'b0;
   endtask
   task automatic cmp(input logic [31:0] v);
      logic [63:0] e;
      e = {32'hFFFFFFFF, ~v};
      if (exp_q.size() != 0) e = exp_q.pop_front();
      samples_checked++;
      if ((v & e[63:32]) !== (e[31:0] & e[63:32])) begin
         miscompares++;
         $display("Error at %0t: got %h expected %h", $time, v, e[31:0]);
      end
   endtask
   always @(posedge pclk) begin
      if ((psel && penable && pready && !pwrite) === 1'b1) cmp(prdata);
      if (snap) cmp({14'h0, alarm_13_1, irq, drive});
   end
   always @(posedge pclk) begin
      cyc++;
      if (cyc == 60000) begin
         miscompares++;
         stop_test();
      end
   end
   function automatic logic [31:0] dv(input logic [5:0] f,
         input logic [8:0] t);
      return {16'h0, f, 1'b0, t};
   endfunction
   function automatic logic [31:0] sel(input logic [3:0] s, o, a,
         input logic [1:0] l, input logic u);
      return {15'h0, u, 2'h0, l, a, o, s};
   endfunction
   task automatic stop_run(input int kd, input logic [3:0] cd,
         input logic cp);
      logic es;
      logic [5:0] f;
      es = kd == 0 ? cd >= 4'h8 : kd == 1 ? cd >= 4'h4 && cp : cd == 4'h2;
      f = es ? {5'h03, kd != 2} : cd[0] ? 6'h11 : 6'h21;
      tq = (kd == 0 && cd == 4'h8) ? 9'h000 :
         9'($unsigned($random(seed)) % 500 + 1);
      apb(1'b1, 8'h08, {23'h0, tq});
      apb(1'b1, 8'h00, kd == 0 ? sel(4'h0, cd, 4'h0, 2'h0, 1'b1) :
         kd == 1 ? sel(4'h0, 4'h0, cd, 2'h0, 1'b1) :
         sel(4'h0, 4'h0, 4'h0, cd[1:0], 1'b1));
      apb(1'b1, 8'h0C, 32'h1);
      cap <= cp;
      idle(20);
      chk(MS, dv(6'h02, 9'h000));
      if (kd == 0) apb(1'b1, 8'h0C, 32'h0);
      else if (kd == 1) alarm_in <= 1'b1;
      else prohibit_in <= 1'b1;
      idle(3);
      chk(es ? MT : MS, dv(f, tq == 9'h000 ? norm : tq));
      for (n = 0; n < 40 && speed_low !== 1'b1; n++) idle(1);
      idle(3);
      if (kd != 2) begin
         f = (kd == 0 && cd >= 4'h8 ? cd[0] : cd[1]) ? 6'h09 : 6'h21;
         chk(MS, dv(f, 9'h000));
         kick <= 1'b1;
         idle(1);
         kick <= 1'b0;
         idle(3);
         chk(MS, dv(f, 9'h000));
      end else begin
         chk(32'h3FE00, {16'h0, 6'h02, cd != 4'h2, 9'h000});
      end
      alarm_in <= 1'b0;
      prohibit_in <= 1'b0;
   endtask
   initial begin
      seed = 31;
      {psel, penable, pwrite, alarm_in, cap, prohibit_in} = 6'h00;
      {kick, cut, snap} = 3'h0;
      paddr = 8'h00;
      pwdata = 32'h0;
      norm = 9'($unsigned($random(seed)) % 501);
      presetn = 1'b0;
      idle(20);
      presetn <= 1'b1;
      chk(MT, dv(6'h08, norm));
      foreach (ra[i]) apb(1'b0, ra[i], rv[i]);
      apb(1'b1, 8'h00, 32'h000100AA);
      apb(1'b1, 8'h00, 32'h00010800);
      apb(1'b1, 8'h00, 32'h00013000);
      apb(1'b0, 8'h00, 32'h00010000);
      apb(1'b1, 8'h04, 32'h45);
      apb(1'b1, 8'h04, 32'h7D1);
      apb(1'b0, 8'h04, 32'h46);
      apb(1'b1, 8'h08, 32'h1F5);
      apb(1'b0, 8'h08, 32'h0);
      repeat (4) begin
         tq = 9'($unsigned($random(seed)) % 501);
         apb(1'b1, 8'h08, {23'h0, tq});
         apb(1'b0, 8'h08, {23'h0, tq});
      end
      for (c = 0; c < 10; c++) stop_run(0, 4'(c), 1'b0);
      for (c = 0; c < 8; c++) stop_run(1, 4'(c), c[0] ^ c[1]);
      for (c = 0; c < 3; c++) stop_run(2, 4'(c), 1'b0);
      apb(1'b1, 8'h00, sel(4'h3, 4'h0, 4'h0, 2'h0, 1'b0));
      apb(1'b1, 8'h18, 32'h1);
      cut <= 1'b1;
      idle(300);
      chk(MS, dv(6'h02, 9'h0));
      idle(58);
      chk(MS, 32'h10000 | dv(6'h11, 9'h0));
      idle(40);
      chk(MS, 32'h10000 | dv(6'h09, 9'h0));
      apb(1'b0, 8'h10, 32'h16);
      apb(1'b1, 8'h14, 32'h1);
      chk(MS, dv(6'h09, 9'h0));
      cut <= 1'b0;
      idle(10);
      chk(MS, dv(6'h02, 9'h0));
      cut <= 1'b1;
      idle(362);
      alarm_in <= 1'b1;
      idle(2);
      chk(MS, 32'h10000 | dv(6'h21, 9'h0));
      alarm_in <= 1'b0;
      cut <= 1'b0;
      apb(1'b1, 8'h14, 32'h7);
      apb(1'b1, 8'h00, sel(4'h0, 4'h0, 4'h5, 2'h0, 1'b1));
      cap <= 1'b0;
      idle(20);
      cut <= 1'b1;
      idle(362);
      chk(MS, 32'h30000 | dv(6'h11, 9'h0));
      cut <= 1'b0;
      apb(1'b1, 8'h14, 32'h7);
      apb(1'b1, 8'h0C, 32'h3);
      idle(5);
      chk(MS, dv(6'h02, 9'h0));
      apb(1'b1, 8'h04, 32'h7D0);
      cut <= 1'b1;
      idle(10100);
      chk(MS, dv(6'h02, 9'h0));
      cut <= 1'b0;
      stop_test();
   end
endmodule
`default_nettype wire
